/* src/capture_reload_timer16_pkg.sv */
// constants, register map and field types for the capture/reload timer
package capture_reload_timer16_pkg;

  // bus geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;

  // register byte addresses
  localparam logic [4:0] CONTROL_OFFSET = 5'h00;
  localparam logic [4:0] MODE_OFFSET = 5'h04;
  localparam logic [4:0] COUNT_LOW_OFFSET = 5'h08;
  localparam logic [4:0] COUNT_HIGH_OFFSET = 5'h0c;
  localparam logic [4:0] RELOAD_LOW_OFFSET = 5'h10;
  localparam logic [4:0] RELOAD_HIGH_OFFSET = 5'h14;

  // field positions in the control register
  localparam int OVF_FLAG_BIT = 7;
  localparam int EXT_FLAG_BIT = 6;
  localparam int RX_SEL_BIT = 5;
  localparam int TX_SEL_BIT = 4;
  localparam int EXT_EN_BIT = 3;
  localparam int RUN_BIT = 2;
  localparam int TC_SEL_BIT = 1;
  localparam int CAP_REL_BIT = 0;

  // field position in the mode register
  localparam int DOWN_EN_BIT = 0;

  // reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic DOWN_EN_RESET = 1'b0;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;

  // oscillator rate and tick dividers
  localparam int OSC_HZ = 10_000_000;
  localparam int MACHINE_DIV = 12;
  localparam int STATE_DIV = 2;
  localparam logic [3:0] MACHINE_LAST = 4'(MACHINE_DIV - 1);
  localparam logic STATE_LAST = 1'(STATE_DIV - 1);

  // control register fields, most significant first
  typedef struct packed {
    logic overflow_flag;
    logic external_event_flag;
    logic rx_clock_select;
    logic tx_clock_select;
    logic external_trigger_enable;
    logic run_control;
    logic timer_counter_select;
    logic capture_reload_select;
  } timer_two_control_t;

  // operating mode derived from control and mode bits
  typedef enum logic [1:0] {
    MODE_RELOAD_UP = 2'b00,
    MODE_RELOAD_UPDOWN = 2'b01,
    MODE_CAPTURE = 2'b10,
    MODE_BAUD = 2'b11
  } timer_mode_t;

endpackage : capture_reload_timer16_pkg

/* src/capture_reload_timer16.sv */
// 16-bit capture / auto-reload / baud-rate timer with an Avalon-MM register slave
// Summary of operation
// - internal mode counts once per twelve oscillator clocks
// - counter mode counts count-pin falling edges
// - run bit gates all counting
// - capture mode rollover sets overflow flag
// - trigger falling edge copies count into reload
// - capture mode never reloads, keeps counting
// - both flags share one interrupt request
// - down-count enable resets to zero
// - up-only reload: rollover sets flag, reloads
// - up-only reload: trigger edge reloads, sets flag
// - up/down, trigger high: count up, reload
// - up/down, trigger low: down, underflow loads max
// - up/down: external flag toggles, no interrupt
// - receive clock select picks this timer's overflows
// - transmit clock select picks this timer's overflows
// - trigger edge ignored unless external enable set
// - capture/reload select picks capture or reload
// - serial clock select forces reload on rollover
// - baud mode counts at half oscillator rate
// - baud mode rollover reloads, sets no flag
// - baud mode trigger edge sets flag only
//
// Added by the designer: register access over Avalon-MM and the address map.
module capture_reload_timer16
  import capture_reload_timer16_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [DATA_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic count_pin_i,
  input wire logic trigger_direction_pin_i,
  input wire logic timer_one_overflow_i,
  output logic irq_o,
  output logic rx_baud_clock_o,
  output logic tx_baud_clock_o
);

  timer_two_control_t ctrl;
  logic down_count_enable;
  logic [15:0] count;
  logic [15:0] reload;
  logic [15:0] next_count;
  logic [15:0] next_reload;
  logic ack;
  logic access;
  logic wr_en;
  logic rd_en;
  logic [3:0] mach_cnt;
  logic state_cnt;
  logic mach_tick;
  logic state_tick;
  logic cnt_s1, cnt_s2, cnt_s3;
  logic trg_s1, trg_s2, trg_s3;
  logic count_fall;
  logic trig_fall;
  logic trig_event;
  logic baud_mode;
  logic tick;
  logic set_ovf;
  logic set_ext;
  logic tog_ext;
  logic baud_wrap;
  timer_mode_t mode;

  // bus handshake: one wait cycle, then the answer
  assign access = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = access & ~ack;
  assign wr_en = avs_write_i & ack & avs_byteenable_i[0];
  assign rd_en = avs_read_i & ~ack;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
    end else begin
      ack <= access & ~ack;
    end
  end

  // read data registered during the wait cycle, stands at the answer edge
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      avs_readdata_o <= '0;
    end else if (rd_en) begin
      case (avs_address_i)
        CONTROL_OFFSET: avs_readdata_o <= {24'h0, ctrl};
        MODE_OFFSET: avs_readdata_o <= {31'h0, down_count_enable};
        COUNT_LOW_OFFSET: avs_readdata_o <= {24'h0, count[7:0]};
        COUNT_HIGH_OFFSET: avs_readdata_o <= {24'h0, count[15:8]};
        RELOAD_LOW_OFFSET: avs_readdata_o <= {24'h0, reload[7:0]};
        RELOAD_HIGH_OFFSET: avs_readdata_o <= {24'h0, reload[15:8]};
        default: avs_readdata_o <= '0;
      endcase
    end
  end

  // machine-cycle and state-time enables from the oscillator clock
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mach_cnt <= 4'h0;
      state_cnt <= 1'b0;
    end else begin
      mach_cnt <= (mach_cnt == MACHINE_LAST) ? 4'h0 : mach_cnt + 4'h1;
      state_cnt <= (state_cnt == STATE_LAST) ? 1'b0 : ~state_cnt;
    end
  end
  assign mach_tick = (mach_cnt == MACHINE_LAST);
  assign state_tick = (state_cnt == STATE_LAST);

  // two-flop synchronisers plus one stage for edge detection
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_s1 <= 1'b1;
      cnt_s2 <= 1'b1;
      cnt_s3 <= 1'b1;
      trg_s1 <= 1'b1;
      trg_s2 <= 1'b1;
      trg_s3 <= 1'b1;
    end else begin
      cnt_s1 <= count_pin_i;
      cnt_s2 <= cnt_s1;
      cnt_s3 <= cnt_s2;
      trg_s1 <= trigger_direction_pin_i;
      trg_s2 <= trg_s1;
      trg_s3 <= trg_s2;
    end
  end
  assign count_fall = cnt_s3 & ~cnt_s2;
  assign trig_fall = trg_s3 & ~trg_s2;
  assign trig_event = ctrl.external_trigger_enable & trig_fall;

  // mode selection; serial clock selects override capture/reload select
  assign baud_mode = ctrl.rx_clock_select | ctrl.tx_clock_select;
  always_comb begin
    if (baud_mode) begin
      mode = MODE_BAUD;
    end else if (ctrl.capture_reload_select) begin
      mode = MODE_CAPTURE;
    end else if (down_count_enable) begin
      mode = MODE_RELOAD_UPDOWN;
    end else begin
      mode = MODE_RELOAD_UP;
    end
  end

  // count enable: pin edges, state time or machine cycle, gated by run
  always_comb begin
    if (!ctrl.run_control) begin
      tick = 1'b0;
    end else if (ctrl.timer_counter_select) begin
      tick = count_fall;
    end else if (baud_mode) begin
      tick = state_tick;
    end else begin
      tick = mach_tick;
    end
  end

  // next count, reload and flag events per mode
  always_comb begin
    next_count = count;
    next_reload = reload;
    set_ovf = 1'b0;
    set_ext = 1'b0;
    tog_ext = 1'b0;
    baud_wrap = 1'b0;
    case (mode)
      MODE_BAUD: begin
        if (tick) begin
          if (count == COUNT_MAX) begin
            next_count = reload;
            baud_wrap = 1'b1;
          end else begin
            next_count = count + 16'h1;
          end
        end
        if (trig_event) begin
          set_ext = 1'b1;
        end
      end
      MODE_CAPTURE: begin
        if (tick) begin
          next_count = count + 16'h1;
          set_ovf = (count == COUNT_MAX);
        end
        if (trig_event) begin
          next_reload = count;
          set_ext = 1'b1;
        end
      end
      MODE_RELOAD_UP: begin
        if (tick) begin
          if (count == COUNT_MAX) begin
            next_count = reload;
            set_ovf = 1'b1;
          end else begin
            next_count = count + 16'h1;
          end
        end
        if (trig_event) begin
          next_count = reload;
          set_ext = 1'b1;
        end
      end
      MODE_RELOAD_UPDOWN: begin
        if (tick) begin
          if (trg_s2) begin
            if (count == COUNT_MAX) begin
              next_count = reload;
              set_ovf = 1'b1;
              tog_ext = 1'b1;
            end else begin
              next_count = count + 16'h1;
            end
          end else if (count == reload) begin
            next_count = COUNT_MAX;
            set_ovf = 1'b1;
            tog_ext = 1'b1;
          end else begin
            next_count = count - 16'h1;
          end
        end
      end
      default: begin
        next_count = count;
      end
    endcase
    // software writes to the data registers win over hardware updates
    if (wr_en && avs_address_i == COUNT_LOW_OFFSET) begin
      next_count[7:0] = avs_writedata_i[7:0];
    end
    if (wr_en && avs_address_i == COUNT_HIGH_OFFSET) begin
      next_count[15:8] = avs_writedata_i[7:0];
    end
    if (wr_en && avs_address_i == RELOAD_LOW_OFFSET) begin
      next_reload[7:0] = avs_writedata_i[7:0];
    end
    if (wr_en && avs_address_i == RELOAD_HIGH_OFFSET) begin
      next_reload[15:8] = avs_writedata_i[7:0];
    end
  end

  // count and capture/reload registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      count <= COUNT_RESET;
      reload <= RELOAD_RESET;
    end else begin
      count <= next_count;
      reload <= next_reload;
    end
  end

  // control register; hardware flag events win over a software clear
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl <= CONTROL_RESET;
    end else begin
      if (wr_en && avs_address_i == CONTROL_OFFSET) begin
        ctrl <= avs_writedata_i[7:0];
        ctrl.overflow_flag <= avs_writedata_i[OVF_FLAG_BIT] | set_ovf;
        ctrl.external_event_flag <= tog_ext ? ~avs_writedata_i[EXT_FLAG_BIT]
                                            : (avs_writedata_i[EXT_FLAG_BIT] | set_ext);
      end else begin
        ctrl.overflow_flag <= ctrl.overflow_flag | set_ovf;
        ctrl.external_event_flag <= tog_ext ? ~ctrl.external_event_flag
                                            : (ctrl.external_event_flag | set_ext);
      end
    end
  end

  // mode register holding the down-count enable
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      down_count_enable <= DOWN_EN_RESET;
    end else if (wr_en && avs_address_i == MODE_OFFSET) begin
      down_count_enable <= avs_writedata_i[DOWN_EN_BIT];
    end
  end

  // shared interrupt request; external flag silent in up/down mode
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= ctrl.overflow_flag
             | (ctrl.external_event_flag & (mode != MODE_RELOAD_UPDOWN));
    end
  end

  // serial receive and transmit clocks: this timer or the other timer
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rx_baud_clock_o <= 1'b0;
      tx_baud_clock_o <= 1'b0;
    end else begin
      rx_baud_clock_o <= ctrl.rx_clock_select ? baud_wrap : timer_one_overflow_i;
      tx_baud_clock_o <= ctrl.tx_clock_select ? baud_wrap : timer_one_overflow_i;
    end
  end

  // checks on the design's own behaviour
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  machine_tick_spacing_a: assert property (
    mach_tick |=> !mach_tick [*8] ##1 !mach_tick ##1 !mach_tick ##1 !mach_tick ##1 mach_tick)
    else $error("machine tick not every twelve clocks");

  stopped_count_holds_a: assert property (
    (!ctrl.run_control && !wr_en && !trig_event) |=> count == $past(count))
    else $error("count moved while stopped");

  capture_keeps_counting_a: assert property (
    (mode == MODE_CAPTURE && tick && !wr_en) |=> count == $past(count) + 16'h1)
    else $error("capture mode did not advance by one");

  capture_copies_count_a: assert property (
    (mode == MODE_CAPTURE && trig_event && !wr_en)
      |=> reload == $past(count) && ctrl.external_event_flag)
    else $error("capture did not copy count");

  up_reload_overflow_a: assert property (
    (mode == MODE_RELOAD_UP && tick && count == COUNT_MAX && !trig_event && !wr_en)
      |=> count == $past(reload) && ctrl.overflow_flag ##1 irq_o)
    else $error("up reload overflow wrong");

  down_underflow_load_a: assert property (
    (mode == MODE_RELOAD_UPDOWN && tick && !trg_s2 && count == reload && !wr_en)
      |=> count == COUNT_MAX && ctrl.overflow_flag)
    else $error("underflow did not load maximum");

  updown_flag_toggle_a: assert property (
    (tog_ext && !wr_en) |=> ctrl.external_event_flag != $past(ctrl.external_event_flag))
    else $error("external flag did not toggle");

  baud_no_overflow_a: assert property (
    (baud_wrap && !wr_en) |=> ctrl.overflow_flag == $past(ctrl.overflow_flag)
      && count == $past(reload))
    else $error("baud rollover touched flag or missed reload");

  baud_receive_clock_a: assert property (
    (baud_wrap && ctrl.rx_clock_select) |=> rx_baud_clock_o)
    else $error("receive clock pulse missing");

  flag_sticky_a: assert property (
    (ctrl.overflow_flag && !(wr_en && avs_address_i == CONTROL_OFFSET))
      |=> ctrl.overflow_flag)
    else $error("overflow flag cleared by hardware");

  down_enable_reset_a: assert property (
    $fell(rst_i) |-> !down_count_enable)
    else $error("down-count enable set after reset");

endmodule : capture_reload_timer16

/* tb/pin_partner.sv */
// far-side model driving the count pin and the trigger/direction pin
module pin_partner (
  input wire logic core_clk_i,
  output logic count_pin_o,
  output logic trigger_pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // both pins idle high, as pulled up
  initial begin
    count_pin_o = 1'b1;
    trigger_pin_o = 1'b1;
  end
  // one high-low-high cycle, each level held four clocks
  task automatic fall(input bit sel);
    @(posedge core_clk_i);
    if (sel) trigger_pin_o <= 1'b0;
    else count_pin_o <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    if (sel) trigger_pin_o <= 1'b1;
    else count_pin_o <= 1'b1;
    repeat (4) @(posedge core_clk_i);
  endtask : fall
  // steady direction level on the trigger pin
  task automatic level(input logic v);
    @(posedge core_clk_i);
    trigger_pin_o <= v;
    repeat (4) @(posedge core_clk_i);
  endtask : level
endmodule : pin_partner

/* tb/testbench.sv */
// self-checking bench for the capture/reload timer
module testbench
  import capture_reload_timer16_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [31:0] exp; int tol; string name;} note_t;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [ADDR_W-1:0] avs_address_i;
  logic avs_read_i;
  logic avs_write_i;
  logic [DATA_W-1:0] avs_writedata_i;
  logic [3:0] avs_byteenable_i;
  logic [DATA_W-1:0] avs_readdata_o;
  logic avs_waitrequest_o, count_pin, trig_pin, irq_o, rx_baud_clock_o, tx_baud_clock_o;
  logic timer_one_overflow_i = 1'b0;
  logic t1_prev = 1'b0;
  logic rx_watch = 1'b0;
  logic [3:0] be = 4'h1;
  logic [7:0] r;
  int n_mismatch = 0;
  int total_checks = 0;
  int n_tx = 0;
  int n_rx = 0;
  int base;
  int base_rx;
  note_t notes[$];

  always #50 core_clk_i = ~core_clk_i;

  capture_reload_timer16 dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .count_pin_i(count_pin), .trigger_direction_pin_i(trig_pin),
    .timer_one_overflow_i(timer_one_overflow_i), .irq_o(irq_o),
    .rx_baud_clock_o(rx_baud_clock_o), .tx_baud_clock_o(tx_baud_clock_o));
  pin_partner partner_u (.core_clk_i(core_clk_i), .count_pin_o(count_pin),
    .trigger_pin_o(trig_pin));

  // compare with optional tolerance; unknown never matches
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got,
                     input int tol);
    total_checks++;
    if (!(got === exp) && !(tol > 0 && (got + tol >= exp && got <= exp + tol) === 1'b1)) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // read results taken off the note queue as they appear
  always @(posedge core_clk_i) begin
    note_t n;
    if (avs_read_i && avs_waitrequest_o === 1'b0 && notes.size() > 0) begin
      n = notes.pop_front();
      chk(n.name, n.exp, avs_readdata_o, n.tol);
    end
  end
  // random other-timer overflows, receive clock follows them, transmit pulses counted
  always @(posedge core_clk_i) begin
    if (rx_watch) chk("rx baud", {31'h0, t1_prev}, {31'h0, rx_baud_clock_o}, 0);
    if (tx_baud_clock_o === 1'b1) n_tx++;
    if (rx_baud_clock_o === 1'b1) n_rx++;
    t1_prev <= timer_one_overflow_i;
    timer_one_overflow_i <= 1'(($urandom % 4) == 0);
  end

  task automatic wait_ack;
    @(posedge core_clk_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge core_clk_i);
  endtask : wait_ack
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    avs_address_i <= a;
    avs_writedata_i <= {24'($urandom), d}; // upper bits must be ignored
    avs_byteenable_i <= {3'($urandom), be[0]};
    avs_write_i <= 1'b1;
    wait_ack();
    avs_write_i <= 1'b0;
    @(posedge core_clk_i);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [31:0] exp, input int tol);
    notes.push_back('{exp, tol, $sformatf("reg %h", a)});
    avs_address_i <= a;
    avs_read_i <= 1'b1;
    wait_ack();
    avs_read_i <= 1'b0;
    @(posedge core_clk_i);
  endtask : rd
  task automatic wr16(input logic [4:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 5'h04, v[15:8]);
  endtask : wr16
  task automatic rd16(input logic [4:0] a, input logic [15:0] v, input int tol);
    rd(a, {24'h0, v[7:0]}, tol);
    rd(a + 5'h04, {24'h0, v[15:8]}, 0);
  endtask : rd16
  task automatic chk_irq(input logic v);
    repeat (2) @(posedge core_clk_i);
    chk("irq", {31'h0, v}, {31'h0, irq_o}, 0);
  endtask : chk_irq
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  // watchdog far beyond the expected run length
  initial begin
    #(20_000 * 100);
    n_mismatch++;
    end_of_test();
  end

  // main sequence
  initial begin
    void'($urandom(44));
    r = 8'($urandom);
    avs_address_i <= '0;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    avs_writedata_i <= '0;
    avs_byteenable_i <= 4'h0;
    repeat (8) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    rx_watch <= 1'b1;
    rd(CONTROL_OFFSET, 32'h0, 0);
    rd(MODE_OFFSET, 32'h0, 0);
    rd16(COUNT_LOW_OFFSET, 16'h0, 0);
    rd16(RELOAD_LOW_OFFSET, 16'h0, 0);
    wr(5'h18, 8'hff);
    rd(5'h18, 32'h0, 0);
    be = 4'h0;
    wr(CONTROL_OFFSET, 8'h04);
    be = 4'h1;
    rd(CONTROL_OFFSET, 32'h0, 0);
    $display("test reset finished");
    // internal ticks over about 242 clocks
    wr(CONTROL_OFFSET, 8'h04);
    repeat (240) @(posedge core_clk_i);
    wr(CONTROL_OFFSET, 8'h00);
    rd16(COUNT_LOW_OFFSET, 16'd20, 1);
    $display("test internal finished");
    // capture on trigger edge across a rollover
    wr(CONTROL_OFFSET, 8'h0b);
    wr16(COUNT_LOW_OFFSET, 16'hfffe);
    wr(CONTROL_OFFSET, 8'h0f);
    repeat (3) partner_u.fall(1'b0);
    partner_u.fall(1'b1);
    partner_u.fall(1'b0);
    rd(CONTROL_OFFSET, 32'hcf, 0);
    chk_irq(1'b1);
    wr(CONTROL_OFFSET, 8'h0b);
    partner_u.fall(1'b0);
    rd16(COUNT_LOW_OFFSET, 16'h0002, 0);
    rd16(RELOAD_LOW_OFFSET, 16'h0001, 0);
    chk_irq(1'b0);
    $display("test capture finished");
    // up-only reload on rollover and on trigger edge
    wr(CONTROL_OFFSET, 8'h0a);
    wr16(RELOAD_LOW_OFFSET, {8'h12, r});
    wr16(COUNT_LOW_OFFSET, 16'hffff);
    wr(CONTROL_OFFSET, 8'h0e);
    partner_u.fall(1'b0);
    rd(CONTROL_OFFSET, 32'h8e, 0);
    wr(CONTROL_OFFSET, 8'h0a);
    rd16(COUNT_LOW_OFFSET, {8'h12, r}, 0);
    wr16(COUNT_LOW_OFFSET, 16'h0005);
    partner_u.fall(1'b1);
    rd(CONTROL_OFFSET, 32'h4a, 0);
    chk_irq(1'b1);
    rd16(COUNT_LOW_OFFSET, {8'h12, r}, 0);
    wr(CONTROL_OFFSET, 8'h06);
    wr(CONTROL_OFFSET, 8'h02);
    wr16(COUNT_LOW_OFFSET, 16'h0005);
    partner_u.fall(1'b1);
    rd(CONTROL_OFFSET, 32'h02, 0);
    rd16(COUNT_LOW_OFFSET, 16'h0005, 0);
    $display("test reload finished");
    // up/down: overflow with pin high, underflow with pin low
    wr(MODE_OFFSET, 8'h01);
    wr16(COUNT_LOW_OFFSET, 16'hffff);
    wr(CONTROL_OFFSET, 8'h06);
    partner_u.fall(1'b0);
    rd(CONTROL_OFFSET, 32'hc6, 0);
    wr(CONTROL_OFFSET, 8'h42);
    chk_irq(1'b0);
    rd16(COUNT_LOW_OFFSET, {8'h12, r}, 0);
    partner_u.level(1'b0);
    wr(CONTROL_OFFSET, 8'h46);
    partner_u.fall(1'b0);
    rd(CONTROL_OFFSET, 32'h86, 0);
    wr(CONTROL_OFFSET, 8'h02);
    rd16(COUNT_LOW_OFFSET, 16'hffff, 0);
    partner_u.level(1'b1);
    wr(MODE_OFFSET, 8'h00);
    $display("test updown finished");
    // baud generator on both receive and transmit sides, capture select ignored
    wr16(RELOAD_LOW_OFFSET, 16'hfff0);
    wr16(COUNT_LOW_OFFSET, 16'hfff0);
    rx_watch <= 1'b0;
    wr(CONTROL_OFFSET, 8'h3d);
    @(posedge core_clk_i);
    base = n_tx;
    base_rx = n_rx;
    repeat (640) @(posedge core_clk_i);
    chk("tx pulses", 32'd20, 32'(n_tx - base), 1);
    chk("rx pulses", 32'd20, 32'(n_rx - base_rx), 1);
    wr(CONTROL_OFFSET, 8'h19);
    wr16(COUNT_LOW_OFFSET, 16'h0005);
    partner_u.fall(1'b1);
    rd(CONTROL_OFFSET, 32'h59, 0);
    rd16(COUNT_LOW_OFFSET, 16'h0005, 0);
    $display("test baud finished");
    end_of_test();
  end
endmodule : testbench
